// file: pmi_core_model.sv
// model of the core exception unit and the off-chip monitor device
// assumes the block's request outputs are registered on hclk
`timescale 1ns/10ps
`default_nettype none

module pmi_core_model (
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // commands from the bench
  input  wire logic       take_en,
  input  wire logic [1:0] take_delay,
  input  wire logic       sysm_assert,
  // block side
  input  wire logic       monitor_exc_req,
  output logic            exc_taken,
  output logic            system_mgmt_input_n
);
  logic [1:0] wait_cnt;
  logic       busy;

  // pin rests high while the off-chip device is quiet
  assign system_mgmt_input_n = ~sysm_assert;

  // one take per request: the request falls a few cycles after the take
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      exc_taken <= 1'b0;
      wait_cnt  <= 2'h0;
      busy      <= 1'b0;
    end else begin
      exc_taken <= 1'b0;
      if (busy) begin
        busy <= monitor_exc_req;
      end else if (monitor_exc_req && take_en) begin
        wait_cnt <= wait_cnt + 2'h1;
        if (wait_cnt == take_delay) begin
          exc_taken <= 1'b1;
          busy      <= 1'b1;
          wait_cnt  <= 2'h0;
        end
      end
    end
  end
endmodule : pmi_core_model

`default_nettype wire

// file: pmi_event_irq.sv
// monitor event counters, interrupt conditions and exception request
// assumes an AHB-Lite master, a time base and retire info on hclk
//
// How it works
// - four 32-bit counters, each counting its own event input
// - counter one msb with its condition enable raises a condition
// - counters two to four msb with shared enable raise a condition
// - time-base enable plus rising edge of selected tap raises an event
// - routed, asserted system-management pin gives a monitor interrupt
// - conditions signal an exception only while exception enable is set
// - request is held back until external interrupt enable is one
// - on signalling, last completed instruction address is captured
// - captured address stays unchanged while the freeze bit is set
// - vector 0x00F00, below external interrupt, above decrementer
// - sampled data address writes accepted, ignored, no exception
// - time-base event may freeze, trigger or signal by own enables
// - changing tap select to a set bit counts as a rising edge
// - user-level read-only views of counters, controls, address
// - mark bit steers the mark-based freeze conditions
// - exception enable clears itself when the interrupt is taken
// - freeze bit stops counting; set by events when freeze enable on
// - writes to user-level views raise a program exception
//
// Added by the designer: the AHB-Lite slave port and the address map.

`timescale 1ns/10ps
`default_nettype none

module pmi_event_irq (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // core state and events
  input  wire logic [3:0]  count_event,
  input  wire logic [31:0] timebase_lower_word,
  input  wire logic [31:0] last_completed_addr,
  input  wire logic        external_interrupt_enable,
  input  wire logic        monitor_mark_bit,
  input  wire logic        problem_state,
  input  wire logic        ext_irq_req,
  input  wire logic        exc_taken,
  // system-management pin
  input  wire logic        system_mgmt_input_n,
  // exception outputs
  output logic             monitor_exc_req,
  output logic             decrementer_hold,
  output logic             sysm_exc_req,
  output logic             program_exc,
  output logic [19:0]      exc_vector,
  output logic             irq
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [31:0]       ctrl_first;
    logic [31:0]       ctrl_third;
    logic [3:0][31:0]  ctr;
    logic [31:0]       sampled;
    logic [pmi_pkg::ST_W-1:0] status;
    logic [pmi_pkg::ST_W-1:0] mask;
    logic              tb_prev;
    logic              pend;
    logic              wr_v;
    logic [7:0]        wr_a;
    logic [31:0]       rdata;
    logic              mon_req;
    logic              dec_hold;
    logic              sysm_req;
    logic              prog;
    logic [19:0]       vec;
    logic              irq;
    logic              rdy;
  } pmi_state_s;

  pmi_state_s st_reg;
  pmi_state_s st_next;

  logic sysm_lvl_n;

  pmi_sync3 u_sysm_sync (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .pin_in    (system_mgmt_input_n),
    .level_out (sysm_lvl_n)
  );

  // ---------------------------------------------------------------
  // read decode, shared by supervisor and user views
  // ---------------------------------------------------------------
  function automatic logic [31:0] rd_mux(input logic [7:0] a, input pmi_state_s s);
    logic [31:0] d;
    d = 32'h0000_0000;
    unique case (a)
      pmi_pkg::ADDR_CTRL_FIRST, pmi_pkg::ADDR_USER_FIRST: d = s.ctrl_first;
      pmi_pkg::ADDR_CTRL_THIRD, pmi_pkg::ADDR_USER_THIRD: d = s.ctrl_third;
      pmi_pkg::ADDR_CTR_BASE,        pmi_pkg::ADDR_USER_CTR:        d = s.ctr[0];
      pmi_pkg::ADDR_CTR_BASE + 8'h4, pmi_pkg::ADDR_USER_CTR + 8'h4: d = s.ctr[1];
      pmi_pkg::ADDR_CTR_BASE + 8'h8, pmi_pkg::ADDR_USER_CTR + 8'h8: d = s.ctr[2];
      pmi_pkg::ADDR_CTR_BASE + 8'hC, pmi_pkg::ADDR_USER_CTR + 8'hC: d = s.ctr[3];
      pmi_pkg::ADDR_SAMPLED, pmi_pkg::ADDR_USER_SAMP: d = s.sampled;
      pmi_pkg::ADDR_INT_STATUS: d = {28'h000_0000, s.status};
      pmi_pkg::ADDR_INT_MASK:   d = {28'h000_0000, s.mask};
      default: d = 32'h0000_0000;
    endcase
    return d;
  endfunction : rd_mux

  // user views sit in a window of their own; any write there is illegal
  function automatic logic is_user(input logic [7:0] a);
    return (a >= pmi_pkg::ADDR_USER_FIRST) && (a <= pmi_pkg::ADDR_USER_SAMP);
  endfunction : is_user

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  logic        ap;
  logic        tb_bit;
  logic        tb_edge;
  logic        sysm_cond;
  logic [3:0]  ovf;
  logic        cond;
  logic        sig;
  logic        cnt_en;
  logic        wr_ok;
  logic [pmi_pkg::ST_W-1:0] st_set;

  always_comb begin
    st_next = st_reg;
    ap      = hsel & htrans[1] & hready;

    // address phase: reads answer from a flop in the data phase
    st_next.wr_v  = ap & hwrite;
    st_next.wr_a  = haddr[7:0];
    st_next.rdata = (ap & ~hwrite) ? rd_mux(haddr[7:0], st_reg) : 32'h0000_0000;
    st_next.rdy   = 1'b1;
    st_next.prog  = 1'b0;
    st_next.vec   = pmi_pkg::VECTOR_OFFSET;

    // time-base tap; the previous tap value is kept, so a select change
    // onto a set bit looks like an edge
    unique case (st_reg.ctrl_first[pmi_pkg::TB_SEL_LO +: 2])
      2'b00: tb_bit = timebase_lower_word[pmi_pkg::TB_TAP0];
      2'b01: tb_bit = timebase_lower_word[pmi_pkg::TB_TAP1];
      2'b10: tb_bit = timebase_lower_word[pmi_pkg::TB_TAP2];
      2'b11: tb_bit = timebase_lower_word[pmi_pkg::TB_TAP3];
    endcase
    tb_edge = st_reg.ctrl_first[pmi_pkg::TB_EN_BIT] & tb_bit & ~st_reg.tb_prev;
    st_next.tb_prev = tb_bit;

    sysm_cond = st_reg.ctrl_third[pmi_pkg::ROUTE_BIT] & ~sysm_lvl_n;
    st_next.sysm_req = ~st_reg.ctrl_third[pmi_pkg::ROUTE_BIT] & ~sysm_lvl_n;

    ovf[0] = st_reg.ctrl_first[pmi_pkg::CE1_BIT] & st_reg.ctr[0][pmi_pkg::CTR_MSB];
    for (int i = 1; i < pmi_pkg::NUM_CTR; i++) begin
      ovf[i] = st_reg.ctrl_first[pmi_pkg::CEN_BIT] & st_reg.ctr[i][pmi_pkg::CTR_MSB];
    end
    cond = (|ovf) | tb_edge | sysm_cond;
    sig  = cond & st_reg.ctrl_first[pmi_pkg::EXC_EN_BIT];

    // counting gates: freeze, privilege and mark
    cnt_en = ~st_reg.ctrl_first[pmi_pkg::FREEZE_BIT]
           & ~(st_reg.ctrl_first[pmi_pkg::FCS_BIT] & ~problem_state)
           & ~(st_reg.ctrl_first[pmi_pkg::FCP_BIT] & problem_state)
           & ~(st_reg.ctrl_first[pmi_pkg::FCM1_BIT] & monitor_mark_bit)
           & ~(st_reg.ctrl_first[pmi_pkg::FCM0_BIT] & ~monitor_mark_bit);
    for (int i = 0; i < pmi_pkg::NUM_CTR; i++) begin
      // counters two to four wait for the trigger while it is armed
      if (cnt_en & count_event[i] & ((i == 0) | ~st_reg.ctrl_first[pmi_pkg::TRIG_BIT])) begin
        st_next.ctr[i] = st_reg.ctr[i] + 32'h0000_0001;
      end
    end

    // sampled address is captured only while the freeze bit is clear
    if (sig & ~st_reg.ctrl_first[pmi_pkg::FREEZE_BIT]) begin
      st_next.sampled = last_completed_addr;
    end

    // data phase write; software loses to hardware set/clear below
    st_set = '0;
    wr_ok  = st_reg.wr_v;
    if (wr_ok) begin
      if (is_user(st_reg.wr_a)) begin
        st_next.prog       = 1'b1;
        st_set[pmi_pkg::ST_ILL] = 1'b1;
      end else begin
        unique case (st_reg.wr_a)
          pmi_pkg::ADDR_CTRL_FIRST:        st_next.ctrl_first = hwdata;
          pmi_pkg::ADDR_CTRL_THIRD:        st_next.ctrl_third = hwdata;
          pmi_pkg::ADDR_CTR_BASE:          st_next.ctr[0]     = hwdata;
          pmi_pkg::ADDR_CTR_BASE + 8'h4:   st_next.ctr[1]     = hwdata;
          pmi_pkg::ADDR_CTR_BASE + 8'h8:   st_next.ctr[2]     = hwdata;
          pmi_pkg::ADDR_CTR_BASE + 8'hC:   st_next.ctr[3]     = hwdata;
          pmi_pkg::ADDR_SAMPLED:           st_next.sampled    = hwdata;
          pmi_pkg::ADDR_SAMPLED_DAT:       st_next.prog       = 1'b0;
          pmi_pkg::ADDR_INT_STATUS:
            st_next.status = st_reg.status & ~hwdata[pmi_pkg::ST_W-1:0];
          pmi_pkg::ADDR_INT_MASK:          st_next.mask = hwdata[pmi_pkg::ST_W-1:0];
          default:                         st_next.prog = 1'b0;
        endcase
      end
    end

    // event effects: freeze, trigger release, enable self-clear
    if (cond & st_reg.ctrl_first[pmi_pkg::FRZ_EVT_BIT]) begin
      st_next.ctrl_first[pmi_pkg::FREEZE_BIT] = 1'b1;
    end
    if (cond) begin
      st_next.ctrl_first[pmi_pkg::TRIG_BIT] = 1'b0;
    end
    if (exc_taken & st_reg.pend) begin
      st_next.ctrl_first[pmi_pkg::EXC_EN_BIT] = 1'b0;
    end

    // one pending request; a new condition wins over the take
    st_next.pend = sig | (st_reg.pend & ~exc_taken & st_reg.ctrl_first[pmi_pkg::EXC_EN_BIT]);

    // deferred by the interrupt enable; the request yields to external interrupts, the decrementer hold does not
    st_next.mon_req  = st_reg.pend & external_interrupt_enable & ~ext_irq_req;
    st_next.dec_hold = st_reg.pend & external_interrupt_enable;

    // sticky status: set beats the write-one clear
    st_set[pmi_pkg::ST_OVF] = |ovf;
    st_set[pmi_pkg::ST_TB]  = tb_edge;
    st_set[pmi_pkg::ST_SYSM] = sysm_cond;
    st_next.status = st_next.status | st_set;
    st_next.irq    = |(st_next.status & st_next.mask);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg            <= '0;
      st_reg.ctrl_first <= pmi_pkg::CTRL_RST;
      st_reg.ctrl_third <= pmi_pkg::CTRL_RST;
      st_reg.ctr        <= {pmi_pkg::NUM_CTR{pmi_pkg::CTR_RST}};
      st_reg.rdy        <= 1'b1;
      st_reg.vec        <= pmi_pkg::VECTOR_OFFSET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign hreadyout        = st_reg.rdy;
  assign hresp            = 1'b0 & st_reg.rdy;
  assign hrdata           = st_reg.rdata;
  assign monitor_exc_req  = st_reg.mon_req;
  assign decrementer_hold = st_reg.dec_hold;
  assign sysm_exc_req     = st_reg.sysm_req;
  assign program_exc      = st_reg.prog;
  assign exc_vector       = st_reg.vec;
  assign irq              = st_reg.irq;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_ovf_one;
    @(posedge hclk) disable iff (!hresetn)
      (st_reg.ctrl_first[pmi_pkg::EXC_EN_BIT] && st_reg.ctrl_first[pmi_pkg::CE1_BIT]
       && st_reg.ctr[0][31]) |=> st_reg.pend;
  endproperty
  a_ovf_one: assert property (p_ovf_one) else $error("counter one overflow not pending");

  property p_ovf_n;
    @(posedge hclk) disable iff (!hresetn)
      (st_reg.ctrl_first[pmi_pkg::CEN_BIT] && st_reg.ctr[3][31])
        |=> st_reg.status[pmi_pkg::ST_OVF];
  endproperty
  a_ovf_n: assert property (p_ovf_n) else $error("counter four overflow lost");

  property p_tb_edge;
    @(posedge hclk) disable iff (!hresetn)
      tb_edge |=> st_reg.status[pmi_pkg::ST_TB] && st_reg.tb_prev;
  endproperty
  a_tb_edge: assert property (p_tb_edge) else $error("time-base edge not recorded");

  property p_smi_route;
    @(posedge hclk) disable iff (!hresetn)
      (!sysm_lvl_n && st_reg.ctrl_third[pmi_pkg::ROUTE_BIT])
        |=> st_reg.status[pmi_pkg::ST_SYSM] && !st_reg.sysm_req;
  endproperty
  a_smi_route: assert property (p_smi_route) else $error("routed pin not taken as monitor");

  property p_pend_needs_enable;
    @(posedge hclk) disable iff (!hresetn)
      st_reg.pend |-> $past(st_reg.ctrl_first[pmi_pkg::EXC_EN_BIT]);
  endproperty
  a_pend_needs_enable: assert property (p_pend_needs_enable) else $error("pending without enable");

  property p_req_gated;
    @(posedge hclk) disable iff (!hresetn)
      monitor_exc_req |-> $past(external_interrupt_enable) && $past(st_reg.pend)
                          && !$past(ext_irq_req);
  endproperty
  a_req_gated: assert property (p_req_gated) else $error("request while interrupts disabled");

  property p_sample;
    @(posedge hclk) disable iff (!hresetn)
      (sig && !st_reg.ctrl_first[pmi_pkg::FREEZE_BIT] && !st_reg.wr_v)
        |=> st_reg.sampled == $past(last_completed_addr);
  endproperty
  a_sample: assert property (p_sample) else $error("sampled address not captured");

  property p_sample_frozen;
    @(posedge hclk) disable iff (!hresetn)
      (st_reg.ctrl_first[pmi_pkg::FREEZE_BIT] && !st_reg.wr_v) |=> $stable(st_reg.sampled);
  endproperty
  a_sample_frozen: assert property (p_sample_frozen) else $error("sampled changed while frozen");

  property p_self_clear;
    @(posedge hclk) disable iff (!hresetn)
      (exc_taken && st_reg.pend) |=> !st_reg.ctrl_first[pmi_pkg::EXC_EN_BIT] ##1 !st_reg.pend;
  endproperty
  a_self_clear: assert property (p_self_clear) else $error("enable not cleared on take");

  property p_frozen_count;
    @(posedge hclk) disable iff (!hresetn)
      (st_reg.ctrl_first[pmi_pkg::FREEZE_BIT] && !st_reg.wr_v) |=> $stable(st_reg.ctr[0]);
  endproperty
  a_frozen_count: assert property (p_frozen_count) else $error("counted while frozen");

  property p_user_write;
    @(posedge hclk) disable iff (!hresetn)
      (st_reg.wr_v && is_user(st_reg.wr_a)) |=> program_exc ##1 !program_exc;
  endproperty
  a_user_write: assert property (p_user_write) else $error("user view write not trapped");

endmodule : pmi_event_irq

`default_nettype wire

// file: pmi_pkg.sv
// constants for the monitor event and interrupt block
// assumes one 10 MHz clock and a single AHB-Lite master

package pmi_pkg;

  // ---------------------------------------------------------------
  // register byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL_FIRST  = 8'h00;
  localparam logic [7:0] ADDR_CTRL_THIRD  = 8'h08;
  localparam logic [7:0] ADDR_CTR_BASE    = 8'h0C;
  localparam logic [7:0] ADDR_SAMPLED     = 8'h1C;
  localparam logic [7:0] ADDR_SAMPLED_DAT = 8'h20;
  localparam logic [7:0] ADDR_INT_STATUS  = 8'h24;
  localparam logic [7:0] ADDR_INT_MASK    = 8'h28;
  localparam logic [7:0] ADDR_USER_FIRST  = 8'h40;
  localparam logic [7:0] ADDR_USER_THIRD  = 8'h44;
  localparam logic [7:0] ADDR_USER_CTR    = 8'h48;
  localparam logic [7:0] ADDR_USER_SAMP   = 8'h58;

  // ---------------------------------------------------------------
  // control field positions (field bit 0 is the msb, held in bit 31)
  // ---------------------------------------------------------------
  localparam int FREEZE_BIT  = 31;
  localparam int FCS_BIT     = 30;
  localparam int FCP_BIT     = 29;
  localparam int FCM1_BIT    = 28;
  localparam int FCM0_BIT    = 27;
  localparam int EXC_EN_BIT  = 26;
  localparam int FRZ_EVT_BIT = 25;
  localparam int TB_SEL_LO   = 23;
  localparam int TB_EN_BIT   = 22;
  localparam int CE1_BIT     = 16;
  localparam int CEN_BIT     = 15;
  localparam int TRIG_BIT    = 14;
  localparam int ROUTE_BIT   = 29;
  localparam int CTR_MSB     = 31;

  // time-base taps chosen by the two-bit select field
  localparam int TB_TAP0 = 31;
  localparam int TB_TAP1 = 23;
  localparam int TB_TAP2 = 19;
  localparam int TB_TAP3 = 15;

  // ---------------------------------------------------------------
  // interrupt status bits
  // ---------------------------------------------------------------
  localparam int ST_OVF  = 0;
  localparam int ST_TB   = 1;
  localparam int ST_SYSM = 2;
  localparam int ST_ILL  = 3;
  localparam int ST_W    = 4;

  // ---------------------------------------------------------------
  // reset values and constants
  // ---------------------------------------------------------------
  localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
  localparam logic [31:0] CTR_RST      = 32'h0000_0000;
  localparam logic        SYNC_RST     = 1'b1;
  localparam logic [19:0] VECTOR_OFFSET = 20'h00F00;
  localparam int          NUM_CTR      = 4;

endpackage : pmi_pkg

// file: pmi_sync3.sv
// three-stage input synchroniser with agreement filter
// assumes the input is asynchronous to hclk

`timescale 1ns/10ps
`default_nettype none

module pmi_sync3 (
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // pin and synchronised level
  input  wire logic pin_in,
  output logic      level_out
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } pmi_sync_s;

  pmi_sync_s st_reg;
  pmi_sync_s st_next;

  // s1 feeds s2 only; the filter looks at s2 and s3
  always_comb begin
    st_next    = st_reg;
    st_next.s1 = pin_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    if (st_reg.s2 == st_reg.s3) begin
      st_next.lvl = st_reg.s3;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= '{s1: pmi_pkg::SYNC_RST, s2: pmi_pkg::SYNC_RST,
                  s3: pmi_pkg::SYNC_RST, lvl: pmi_pkg::SYNC_RST};
    end else begin
      st_reg <= st_next;
    end
  end

  assign level_out = st_reg.lvl;

endmodule : pmi_sync3

`default_nettype wire

// file: test_perf_monitor_event_interrupt.sv
// self-checking bench for the monitor event and interrupt block
// assumes pmi_pkg, the design files and pmi_core_model compiled first
`timescale 1ns/10ps
`default_nettype none

module test_perf_monitor_event_interrupt;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd_cap, timebase_lower_word, last_completed_addr;
  logic [1:0]  htrans, take_delay;
  logic [2:0]  hsize;
  logic [3:0]  count_event;
  logic [19:0] exc_vector;
  logic        external_interrupt_enable, monitor_mark_bit, problem_state, ext_irq_req;
  logic        exc_taken, system_mgmt_input_n, monitor_exc_req, decrementer_hold;
  logic        sysm_exc_req, program_exc, irq, take_en, sysm_assert;
  logic [31:0] prog_cnt = 32'h0;
  int          err_count = 0;
  int          compares = 0;
  int          cycles = 0;
  localparam logic [31:0] FRZ    = 32'h1 << pmi_pkg::FREEZE_BIT;
  localparam logic [31:0] XEN    = 32'h1 << pmi_pkg::EXC_EN_BIT;
  localparam logic [31:0] FRZ_EV = 32'h1 << pmi_pkg::FRZ_EVT_BIT;
  localparam logic [31:0] TB_EN  = 32'h1 << pmi_pkg::TB_EN_BIT;
  localparam logic [31:0] CE1   = 32'h1 << pmi_pkg::CE1_BIT;
  localparam logic [31:0] CEN   = 32'h1 << pmi_pkg::CEN_BIT;
  localparam logic [7:0]  C0    = pmi_pkg::ADDR_CTRL_FIRST;
  localparam logic [7:0]  CTR   = pmi_pkg::ADDR_CTR_BASE;
  localparam logic [7:0]  ST    = pmi_pkg::ADDR_INT_STATUS;
  localparam logic [7:0]  SA    = pmi_pkg::ADDR_SAMPLED;
  localparam int          TAPS [4] = '{31, 23, 19, 15};

  assign hready = hreadyout;

  pmi_event_irq DUT (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .count_event, .timebase_lower_word,
    .last_completed_addr, .external_interrupt_enable, .monitor_mark_bit,
    .problem_state, .ext_irq_req, .exc_taken, .system_mgmt_input_n,
    .monitor_exc_req, .decrementer_hold, .sysm_exc_req, .program_exc, .exc_vector, .irq
  );
  pmi_core_model u_core (
    .hclk, .hresetn, .take_en, .take_delay, .sysm_assert, .monitor_exc_req,
    .exc_taken, .system_mgmt_input_n
  );

  // ---------------------------------------------------------------
  // clock, capture and timeout
  // ---------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    rd_cap <= hrdata;
    if (program_exc === 1'b1) begin
      prog_cnt <= prog_cnt + 32'h1;
    end
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      close_out();
    end
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic cb(input logic g, input logic e);
    chk({31'h0, g}, {31'h0, e});
  endtask : cb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= 1'b1;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= 1'b0;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    do @(posedge hclk); while (hready !== 1'b1);
    #1 chk(rd_cap, e);
  endtask : rd
  task automatic wt(input int n);
    repeat (n) @(posedge hclk);
    @(negedge hclk);
  endtask : wt
  task automatic close_out();
    if (err_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0;
    hsize = 3'b010; hwdata = 32'h0; count_event = 4'h0; timebase_lower_word = 32'h0;
    last_completed_addr = 32'h0; external_interrupt_enable = 1'b0; monitor_mark_bit = 1'b0;
    problem_state = 1'b0; ext_irq_req = 1'b0; take_en = 1'b0; take_delay = 2'h0;
    sysm_assert = 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    wt(1);
    chk({12'h0, exc_vector}, 32'h0000_0F00);
    // all four counters count one per strobe cycle, user view matches
    @(posedge hclk);
    count_event <= 4'hF;
    repeat (3) @(posedge hclk);
    count_event <= 4'h0;
    for (int i = 0; i < 4; i++) begin
      rd(CTR + 8'(4 * i), 32'h3);
      rd(pmi_pkg::ADDR_USER_CTR + 8'(4 * i), 32'h3);
    end
    wr(C0, FRZ);
    count_event <= 4'h1;
    wt(3);
    count_event <= 4'h0;
    rd(CTR, 32'h3);
    // overflow held back by interrupt enable, then by external interrupt
    last_completed_addr <= 32'h0000_4A40;
    wr(CTR, 32'h8000_0000);
    wr(pmi_pkg::ADDR_INT_MASK, 32'hF);
    wr(C0, CE1 | XEN);
    wt(3);
    cb(irq, 1'b1);
    cb(monitor_exc_req, 1'b0);
    cb(decrementer_hold, 1'b0);
    rd(SA, 32'h0000_4A40);
    ext_irq_req <= 1'b1;
    external_interrupt_enable <= 1'b1;
    wt(3);
    cb(monitor_exc_req, 1'b0);
    cb(decrementer_hold, 1'b1);
    ext_irq_req <= 1'b0;
    wt(3);
    cb(monitor_exc_req, 1'b1);
    take_delay <= 2'h2;
    take_en <= 1'b1;
    wt(8);
    cb(monitor_exc_req, 1'b0);
    rd(C0, CE1);
    take_en <= 1'b0;
    last_completed_addr <= 32'h0000_5B50;
    wr(C0, FRZ | CE1 | XEN);
    wt(3);
    rd(SA, 32'h0000_4A40);
    wr(C0, FRZ_EV | CE1 | XEN);
    wt(2);
    rd(C0, FRZ | FRZ_EV | CE1 | XEN);
    wr(CTR, 32'h0);
    wr(C0, 32'h0);
    wr(ST, 32'hF);
    rd(ST, 32'h0);
    // counters two to four share one enable; no exception without enable
    for (int i = 1; i < 4; i++) begin
      wr(CTR + 8'(4 * i), 32'h8000_0000);
      wr(C0, CEN);
      wt(2);
      cb(decrementer_hold, 1'b0);
      rd(ST, 32'h1);
      wr(CTR + 8'(4 * i), 32'h0);
      wr(C0, 32'h0);
      wr(ST, 32'hF);
    end
    // each tap select on a rising time-base bit
    for (int s = 0; s < 4; s++) begin
      wr(C0, TB_EN | (32'(s) << pmi_pkg::TB_SEL_LO));
      wr(ST, 32'hF);
      timebase_lower_word <= 32'h1 << TAPS[s];
      wt(2);
      rd(ST, 32'h2);
    end
    timebase_lower_word <= 32'h8000_0000;
    wr(ST, 32'hF);
    wr(C0, TB_EN);
    wt(2);
    rd(ST, 32'h2);
    wr(C0, 32'h0);
    wr(ST, 32'hF);
    // system-management pin, unrouted then routed
    sysm_assert <= 1'b1;
    wt(8);
    cb(sysm_exc_req, 1'b1);
    wr(pmi_pkg::ADDR_CTRL_THIRD, 32'h1 << pmi_pkg::ROUTE_BIT);
    wt(2);
    cb(sysm_exc_req, 1'b0);
    rd(ST, 32'h4);
    sysm_assert <= 1'b0;
    wr(pmi_pkg::ADDR_CTRL_THIRD, 32'h0);
    wt(8);
    wr(ST, 32'hF);
    // writes to read-only views and to the absent data address register
    wr(pmi_pkg::ADDR_USER_FIRST, FRZ);
    wt(2);
    chk(prog_cnt, 32'h1);
    rd(C0, 32'h0);
    wr(pmi_pkg::ADDR_SAMPLED_DAT, 32'h0000_0ABC);
    wt(2);
    chk(prog_cnt, 32'h1);
    rd(pmi_pkg::ADDR_SAMPLED_DAT, 32'h0);
    rd(8'h30, 32'h0);
    rd(ST, 32'h8);
    wr(pmi_pkg::ADDR_INT_MASK, 32'h0);
    wt(1);
    cb(irq, 1'b0);
    wr(pmi_pkg::ADDR_INT_MASK, 32'h8);
    wt(1);
    cb(irq, 1'b1);
    wr(ST, 32'h8);
    wt(1);
    cb(irq, 1'b0);
    close_out();
  end
endmodule : test_perf_monitor_event_interrupt

`default_nettype wire
